/* File: logic/srx_pkg.sv */
package srx_pkg;

    // Serial bits per received code group; the recovered clock is this
    // many serial bit times long.
    localparam int unsigned SRX_GROUP_BITS   = 20;
    localparam int unsigned SRX_HALF_GROUP   = 10;
    localparam int unsigned SRX_DATA_BITS    = 16;

    // Power-on reset length, in microseconds, and its cycle count.
    localparam int unsigned SRX_CLK_MHZ      = 40;
    localparam int unsigned SRX_POR_US       = 10;
    localparam int unsigned SRX_POR_CYCLES   = SRX_POR_US * SRX_CLK_MHZ;

    // Preemphasis levels in percent.
    localparam logic [4:0]  SRX_PRE_LOW_PCT  = 5'h05;
    localparam logic [4:0]  SRX_PRE_HIGH_PCT = 5'h14;

    // Comma-bearing K28 code group, running disparity negative and positive.
    localparam logic [9:0]  SRX_K28_5_NEG    = 10'h0fa;
    localparam logic [9:0]  SRX_K28_5_POS    = 10'h305;

    // Interrupt status and mask bit positions.
    localparam int unsigned SRX_EV_LOS       = 0;
    localparam int unsigned SRX_EV_PRBS_FAIL = 1;
    localparam int unsigned SRX_EV_CODE_ERR  = 2;
    localparam int unsigned SRX_EV_WIDTH     = 3;

    // Register offsets on the local control port, and the mask register reset value.
    localparam logic [3:0]  SRX_REG_STATUS   = 4'h0;
    localparam logic [3:0]  SRX_REG_MASK     = 4'h4;
    localparam logic [3:0]  SRX_REG_MODE     = 4'h8;
    localparam logic [3:0]  SRX_REG_COUNT    = 4'hc;
    localparam logic [2:0]  SRX_MASK_RESET   = 3'h0;

    typedef enum logic [1:0] {
        SRX_ST_DOWN,
        SRX_ST_POR,
        SRX_ST_RUN
    } srx_state_type;

endpackage

/* File: logic/srx_dec8b10b.sv */
`timescale 1ns/100ps
`default_nettype none
// One 10-bit to 8-bit decoder with running disparity not tracked; the
// six/four sub-block tables cover every valid code group except D.31, which sets err_o.
module srx_dec8b10b (
    input  wire logic [9:0] code_i,
    output logic      [7:0] byte_o,
    output logic            k_o,
    output logic            err_o
);
    logic [4:0] lo5;
    logic [2:0] hi3;
    logic       bad6;
    logic       bad4;

    always_comb begin
        lo5  = 5'h00;
        bad6 = 1'b0;
        case (code_i[9:4])
            6'h27, 6'h18: lo5 = 5'h00;
            6'h1d, 6'h22: lo5 = 5'h01;
            6'h2d, 6'h12: lo5 = 5'h02;
            6'h31:        lo5 = 5'h03;
            6'h35, 6'h0a: lo5 = 5'h04;
            6'h29:        lo5 = 5'h05;
            6'h19:        lo5 = 5'h06;
            6'h38, 6'h07: lo5 = 5'h07;
            6'h39, 6'h06: lo5 = 5'h08;
            6'h25:        lo5 = 5'h09;
            6'h15:        lo5 = 5'h0a;
            6'h34:        lo5 = 5'h0b;
            6'h0d:        lo5 = 5'h0c;
            6'h2c:        lo5 = 5'h0d;
            6'h1c:        lo5 = 5'h0e;
            6'h17, 6'h28: lo5 = 5'h0f;
            6'h1b, 6'h24: lo5 = 5'h10;
            6'h23:        lo5 = 5'h11;
            6'h13:        lo5 = 5'h12;
            6'h32:        lo5 = 5'h13;
            6'h0b:        lo5 = 5'h14;
            6'h2a:        lo5 = 5'h15;
            6'h1a:        lo5 = 5'h16;
            6'h3a, 6'h05: lo5 = 5'h17;
            6'h33, 6'h0c: lo5 = 5'h18;
            6'h26:        lo5 = 5'h19;
            6'h16:        lo5 = 5'h1a;
            6'h36, 6'h09: lo5 = 5'h1b;
            6'h0e:        lo5 = 5'h1c;
            6'h0f, 6'h30: lo5 = 5'h1c;
            6'h2e, 6'h11: lo5 = 5'h1d;
            6'h1e, 6'h21: lo5 = 5'h1e;
            default:      bad6 = 1'b1;
        endcase
    end

    always_comb begin
        hi3  = 3'h0;
        bad4 = 1'b0;
        case (code_i[3:0])
            4'hb, 4'h4:           hi3 = 3'h0;
            4'h9:                 hi3 = 3'h1;
            4'h5:                 hi3 = 3'h2;
            4'hc, 4'h3:           hi3 = 3'h3;
            4'hd, 4'h2:           hi3 = 3'h4;
            4'ha:                 hi3 = 3'h5;
            4'h6:                 hi3 = 3'h6;
            4'he, 4'h1, 4'h7,
            4'h8:                 hi3 = 3'h7;
            default:              bad4 = 1'b1;
        endcase
    end

    // K codes are K28.x (abcdei = 001111 or 110000) and K23/27/29/30.7
    // whose six-bit half is followed by the alternate 0111/1000 form.
    assign k_o    = (code_i[9:4] == 6'h0f) || (code_i[9:4] == 6'h30) ||
                    (((code_i[3:0] == 4'h7) || (code_i[3:0] == 4'h8)) &&
                     ((lo5 == 5'h17) || (lo5 == 5'h1b) ||
                      (lo5 == 5'h1d) || (lo5 == 5'h1e)));
    assign byte_o = {hi3, lo5};
    assign err_o  = bad6 | bad4;

endmodule
`default_nettype wire

/* File: logic/srx_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Enable low keeps device powered down; only signal detect stays alive.
// - Enable rising from power-down passes through power-on reset first.
// - Lock-to-reference low locks receive clock to transmit reference.
// - Lock-to-reference low tri-states receive data, recovered clock, K flags.
// - Lock-to-reference high locks recovery to incoming serial data.
// - Loopback high routes own transmit serial data into receiver.
// - During loopback both serial transmit outputs are high impedance.
// - Preemphasis 5% when select low, 20% when high.
// - PRBS enable puts PRBS pass status on low-byte K flag.
// - Low-byte K flag high for K character on bits 0-7, else low.
// - High-byte K flag high for K character on bits 8-15, else low.
// - Loss of signal forces all receive data and both K flags high.
// - Recovered clock is serial bit rate over 20; outputs synchronous.
// - Recovered clock held low throughout power-on reset.
// - Each 20-bit code group decodes 8b/10b into 16 data bits.
// - Receive data valid at recovered clock rising edge.
// - Receive data outputs high impedance during power-on reset.
module srx_ctrl
    import srx_pkg::*;
#(
    parameter int unsigned POR_CYCLES = SRX_POR_CYCLES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        device_enable_i,
    input  wire logic        lock_to_reference_n_i,
    input  wire logic        loopback_enable_i,
    input  wire logic        preemphasis_high_i,
    input  wire logic        prbs_test_enable_i,
    input  wire logic        serial_bit_i,
    input  wire logic        tx_serial_bit_i,
    input  wire logic        signal_detect_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    output logic             irq_o,
    output logic      [15:0] rx_data_o,
    output logic             rx_data_oe_o,
    output logic             rx_k_flag_low_byte_o,
    output logic             rx_k_flag_high_byte_o,
    output logic             rx_flags_oe_o,
    output logic             recovered_clock_o,
    output logic             recovered_clock_oe_o,
    output logic             serial_out_o,
    output logic             serial_out_oe_o,
    output logic      [4:0]  preemphasis_pct_o,
    output logic             rx_powered_o,
    output logic             rx_ref_locked_o
);
    srx_state_type state_r;
    logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_r;
    logic [19:0] shift_r;
    logic [4:0]  bit_cnt_r;
    logic        aligned_r;
    logic        group_tick;
    logic        word_load;
    logic        rx_bit;
    logic [19:0] group;
    logic [7:0]  byte_lo;
    logic [7:0]  byte_hi;
    logic        k_lo;
    logic        k_hi;
    logic        err_lo;
    logic        err_hi;
    logic [15:0] data_r;
    logic        k_lo_r;
    logic        k_hi_r;
    logic        rclk_r;
    logic [6:0]  lfsr_r;
    logic        prbs_ok_r;
    logic        prbs_miss_r;
    logic        prbs_bad;
    logic [SRX_EV_WIDTH-1:0] status_r;
    logic [SRX_EV_WIDTH-1:0] mask_r;
    logic [SRX_EV_WIDTH-1:0] events;
    logic [15:0] err_cnt_r;
    logic        running;
    logic        los;

    assign running = (state_r == SRX_ST_RUN);
    assign los     = !signal_detect_i;

    // Signal detect stays live in power-down so software sees it.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r   <= SRX_ST_DOWN;
            por_cnt_r <= '0;
        end else begin
            case (state_r)
                SRX_ST_DOWN: begin
                    por_cnt_r <= '0;
                    if (device_enable_i) begin
                        state_r <= SRX_ST_POR;
                    end
                end
                SRX_ST_POR: begin
                    if (!device_enable_i) begin
                        state_r <= SRX_ST_DOWN;
                    end else if (por_cnt_r == POR_CYCLES[$bits(por_cnt_r)-1:0]
                                 - 1'b1) begin
                        state_r <= SRX_ST_RUN;
                    end else begin
                        por_cnt_r <= por_cnt_r + 1'b1;
                    end
                end
                default: begin
                    if (!device_enable_i) begin
                        state_r <= SRX_ST_DOWN;
                    end
                end
            endcase
        end
    end

    // Lock-to-reference makes the group counter free-run on the system
    // (reference) clock rather than realigning on commas from the line.
    assign rx_bit     = loopback_enable_i ? tx_serial_bit_i
                                          : serial_bit_i;
    assign group      = {shift_r[18:0], rx_bit};
    assign group_tick = running &&
                        (bit_cnt_r == 5'(SRX_GROUP_BITS - 1));
    // A realignment that lands before mid-group leaves the recovered clock
    // low at the next boundary; that group is dropped rather than letting
    // the word change without a clock edge.
    assign word_load  = group_tick && rclk_r;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shift_r   <= '0;
            bit_cnt_r <= '0;
            aligned_r <= 1'b0;
        end else if (!running) begin
            bit_cnt_r <= '0;
            aligned_r <= 1'b0;
        end else begin
            shift_r <= group;
            if (lock_to_reference_n_i && !aligned_r &&
                ((group[9:0] == SRX_K28_5_NEG) ||
                 (group[9:0] == SRX_K28_5_POS))) begin
                bit_cnt_r <= 5'(SRX_HALF_GROUP);
                aligned_r <= 1'b1;
            end else if (group_tick) begin
                bit_cnt_r <= '0;
            end else begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    srx_dec8b10b u_dec_lo (
        .code_i (group[19:10]),
        .byte_o (byte_lo),
        .k_o    (k_lo),
        .err_o  (err_lo)
    );

    srx_dec8b10b u_dec_hi (
        .code_i (group[9:0]),
        .byte_o (byte_hi),
        .k_o    (k_hi),
        .err_o  (err_hi)
    );

    // Data and flags load together at the group boundary, half a
    // recovered-clock period before its rising edge.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            data_r <= '0;
            k_lo_r <= 1'b0;
            k_hi_r <= 1'b0;
        end else if (word_load) begin
            if (los) begin
                data_r <= 16'hffff;
                k_lo_r <= 1'b1;
                k_hi_r <= 1'b1;
            end else begin
                data_r <= {byte_hi, byte_lo};
                k_lo_r <= prbs_test_enable_i ? prbs_ok_r : k_lo;
                k_hi_r <= k_hi;
            end
        end
    end

    // Recovered clock: low first half of the group, high second half.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rclk_r <= 1'b0;
        end else if (!running) begin
            rclk_r <= 1'b0;
        end else if (group_tick) begin
            rclk_r <= 1'b0;
        end else if (bit_cnt_r == 5'(SRX_HALF_GROUP - 1)) begin
            rclk_r <= 1'b1;
        end
    end

    // PRBS-7 self-synchronising checker; pass means a full group with no
    // mismatch, which trades fast fail reporting for a stable flag.
    assign prbs_bad = (rx_bit != (lfsr_r[6] ^ lfsr_r[5]));

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lfsr_r      <= '0;
            prbs_ok_r   <= 1'b0;
            prbs_miss_r <= 1'b0;
        end else if (running && prbs_test_enable_i) begin
            lfsr_r <= {lfsr_r[5:0], rx_bit};
            if (group_tick) begin
                prbs_ok_r   <= !prbs_miss_r && !prbs_bad && (|lfsr_r);
                prbs_miss_r <= 1'b0;
            end else if (prbs_bad) begin
                prbs_miss_r <= 1'b1;
            end
        end else begin
            prbs_ok_r   <= 1'b0;
            prbs_miss_r <= 1'b0;
        end
    end

    assign events[SRX_EV_LOS]       = running && los && group_tick;
    assign events[SRX_EV_PRBS_FAIL] = group_tick && prbs_test_enable_i &&
                                      !prbs_ok_r;
    assign events[SRX_EV_CODE_ERR]  = group_tick && !los && !prbs_test_enable_i
                                      && (err_lo || err_hi);

    // Set wins over a clearing read in the same cycle.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_r <= '0;
        end else if (reg_rd_i && reg_addr_i == SRX_REG_STATUS) begin
            status_r <= events;
        end else begin
            status_r <= status_r | events;
        end
    end

    // A clearing write beats a code error in the same cycle; the counter
    // saturates rather than wrapping so a flood of errors stays visible.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mask_r    <= SRX_MASK_RESET;
            err_cnt_r <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == SRX_REG_MASK) begin
                mask_r <= reg_wdata_i[SRX_EV_WIDTH-1:0];
            end
            if (reg_wr_i && reg_addr_i == SRX_REG_COUNT) begin
                err_cnt_r <= '0;
            end else if (events[SRX_EV_CODE_ERR] && err_cnt_r != 16'hffff) begin
                err_cnt_r <= err_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= '0;
        end else if (reg_addr_i == SRX_REG_STATUS) begin
            reg_rdata_o <= {29'h0, status_r};
        end else if (reg_addr_i == SRX_REG_MASK) begin
            reg_rdata_o <= {29'h0, mask_r};
        end else if (reg_addr_i == SRX_REG_MODE) begin
            reg_rdata_o <= {24'h0, signal_detect_i, aligned_r,
                            prbs_test_enable_i, preemphasis_high_i,
                            loopback_enable_i, lock_to_reference_n_i,
                            state_r};
        end else if (reg_addr_i == SRX_REG_COUNT) begin
            reg_rdata_o <= {16'h0, err_cnt_r};
        end else begin
            reg_rdata_o <= '0;
        end
    end

    assign irq_o = |(status_r & mask_r);

    assign rx_data_o             = data_r;
    assign rx_k_flag_low_byte_o  = k_lo_r;
    assign rx_k_flag_high_byte_o = k_hi_r;
    assign rx_data_oe_o          = running && lock_to_reference_n_i;
    assign rx_flags_oe_o         = running && lock_to_reference_n_i;
    assign recovered_clock_o     = rclk_r;
    // Low during power-on reset is an active drive, not a float, unless
    // lock-to-reference is low, which floats the recovered clock.
    assign recovered_clock_oe_o  = (state_r != SRX_ST_DOWN) &&
                                   lock_to_reference_n_i;
    assign serial_out_o          = tx_serial_bit_i;
    assign serial_out_oe_o       = running && !loopback_enable_i;
    assign preemphasis_pct_o     = preemphasis_high_i ? SRX_PRE_HIGH_PCT
                                                      : SRX_PRE_LOW_PCT;
    assign rx_powered_o          = (state_r != SRX_ST_DOWN);
    assign rx_ref_locked_o       = !lock_to_reference_n_i;

endmodule
`default_nettype wire

/* File: tb/srx_props.sv */
`timescale 1ns/100ps
`default_nettype none
module srx_props
    import srx_pkg::*;
#(
    parameter int unsigned POR_CYCLES = SRX_POR_CYCLES
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        device_enable_i,
    input wire logic        lock_to_reference_n_i,
    input wire logic        loopback_enable_i,
    input wire logic        preemphasis_high_i,
    input wire logic        prbs_test_enable_i,
    input wire logic        signal_detect_i,
    input wire logic [15:0] rx_data_o,
    input wire logic        rx_data_oe_o,
    input wire logic        rx_k_flag_low_byte_o,
    input wire logic        rx_k_flag_high_byte_o,
    input wire logic        rx_flags_oe_o,
    input wire logic        recovered_clock_o,
    input wire logic        recovered_clock_oe_o,
    input wire logic        serial_out_oe_o,
    input wire logic [4:0]  preemphasis_pct_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    chk_down_dark: assert property (
        !device_enable_i |=> !rx_data_oe_o && !rx_flags_oe_o)
        else $error("receive side driven while disabled");
    chk_por_hiz: assert property (
        $rose(device_enable_i) |=> (!rx_data_oe_o)[*3])
        else $error("receive data driven during power-on reset");
    chk_por_clk: assert property (
        $rose(device_enable_i) |=> (!recovered_clock_o)[*3])
        else $error("recovered clock not low during power-on reset");
    chk_ref_hiz: assert property (
        !lock_to_reference_n_i |-> !rx_data_oe_o && !rx_flags_oe_o
        && !recovered_clock_oe_o)
        else $error("receive side driven while locked to reference");
    chk_loop_hiz: assert property (
        loopback_enable_i |-> !serial_out_oe_o)
        else $error("serial output driven during loopback");
    chk_pre_level: assert property (
        preemphasis_pct_o == (preemphasis_high_i ? SRX_PRE_HIGH_PCT
        : SRX_PRE_LOW_PCT))
        else $error("wrong preemphasis level");
    chk_los_ones: assert property (
        $fell(recovered_clock_o) && rx_data_oe_o && !prbs_test_enable_i
        && !$past(signal_detect_i) && !$past(signal_detect_i, 2)
        |-> rx_data_o == 16'hffff && rx_k_flag_low_byte_o
        && rx_k_flag_high_byte_o)
        else $error("loss of signal did not force ones");
    chk_rclk_low: assert property (
        $fell(recovered_clock_o) |=> (!recovered_clock_o)[*8])
        else $error("recovered clock low phase too short");
    chk_word_edge: assert property (
        device_enable_i && lock_to_reference_n_i && ($changed(rx_data_o)
        || $changed(rx_k_flag_high_byte_o)) |-> $fell(recovered_clock_o))
        else $error("receive word changed off the clock fall");
    cov_los: cover property ($fell(recovered_clock_o) && &rx_data_o);
    cov_loop: cover property (loopback_enable_i && $rose(recovered_clock_o));
    cov_prbs: cover property (prbs_test_enable_i && rx_k_flag_low_byte_o);
endmodule
`default_nettype wire

/* File: tb/srx_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
// Streams a group every 20 cycles without gaps, because the receiver
// aligns only once and any pause would shift its group boundary.
module srx_far_end (
    input  wire logic        clk_sys_i,
    input  wire logic        run_i,
    input  wire logic        prbs_i,
    output logic             line_o,
    output logic             sig_det_o,
    output logic             done_o,
    output logic      [17:0] note_o
);
    localparam logic [39:0] FILL = {1'b0, 18'h0, 1'b1, 10'h2aa, 10'h2aa};
    logic [39:0] q[$];
    logic [39:0] cur = FILL;
    logic [6:0]  lfsr = 7'h7f;
    int          cnt = 0;
    initial begin
        line_o = 1'b0;
        sig_det_o = 1'b1;
        done_o = 1'b0;
        note_o = 18'h0;
    end
    always @(posedge clk_sys_i) begin
        if (!run_i) begin
            line_o <= ~line_o;
            done_o <= 1'b0;
        end else begin
            if (cnt == 0) begin
                cur = (q.size() != 0) ? q.pop_front() : FILL;
            end
            if (prbs_i) begin
                lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
                line_o <= lfsr[0];
            end else begin
                line_o <= cur[19 - cnt];
            end
            sig_det_o <= cur[20];
            done_o <= (cnt == 19) && cur[39] && !prbs_i;
            note_o <= cur[38:21];
            cnt = (cnt == 19) ? 0 : cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import srx_pkg::*;
    localparam int unsigned POR_CYCLES = 4;
    localparam logic [9:0] CODE [5] = '{10'h274, 10'h2aa, 10'h155,
                                        10'h3a8, 10'h0fa};
    localparam logic [8:0] CHAR [5] = '{9'h000, 9'h0b5, 9'h04a,
                                        9'h1f7, 9'h1bc};
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        device_enable_i = 1'b0;
    logic        lock_to_reference_n_i = 1'b1;
    logic        loopback_enable_i = 1'b0;
    logic        preemphasis_high_i = 1'b0;
    logic        prbs_test_enable_i = 1'b0;
    logic        run = 1'b0;
    logic        idle_bit = 1'b0;
    logic        rd_pend = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        line, sig_det, done;
    logic [17:0] note, exp_w;
    logic [63:0] rd_it;
    wire logic   serial_bit_i, tx_serial_bit_i, signal_detect_i;
    logic [31:0] reg_rdata_o;
    logic [15:0] rx_data_o;
    logic [4:0]  preemphasis_pct_o;
    logic        irq_o, rx_data_oe_o, rx_k_flag_low_byte_o, rx_flags_oe_o;
    logic        rx_k_flag_high_byte_o, recovered_clock_o, serial_out_o;
    logic        recovered_clock_oe_o, serial_out_oe_o, rx_powered_o;
    logic        rx_ref_locked_o;
    logic [17:0] exp_q[$];
    logic [63:0] rd_q[$];
    int          err_count = 0;
    int          check_count = 0;
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // The unused serial path carries a toggling level, never a stale bit.
    always @(posedge clk_sys_i) idle_bit <= ~idle_bit;
    assign serial_bit_i = loopback_enable_i ? idle_bit : line;
    assign tx_serial_bit_i = loopback_enable_i ? line : idle_bit;
    assign signal_detect_i = sig_det;
    srx_ctrl #(.POR_CYCLES(POR_CYCLES)) i_srx_ctrl (.*);
    srx_far_end i_srx_far_end (.clk_sys_i(clk_sys_i), .run_i(run),
        .prbs_i(prbs_test_enable_i), .line_o(line), .sig_det_o(sig_det),
        .done_o(done), .note_o(note));
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        rd_q.push_back({m, e});
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
    endtask
    task automatic grp(input int lo, input int hi, input logic det);
        logic [17:0] n;
        n = {CHAR[hi][7:0], CHAR[lo][7:0], CHAR[lo][8], CHAR[hi][8]};
        if (!det) n = 18'h3ffff;
        i_srx_far_end.q.push_back({1'b1, n, det, CODE[lo], CODE[hi]});
    endtask
    task automatic settle();
        int t;
        t = 0;
        while (i_srx_far_end.q.size() != 0 && t < 2000) begin
            @(posedge clk_sys_i);
            t++;
        end
        repeat (45) @(posedge clk_sys_i);
        chk("words pending", 32'h0, 32'(exp_q.size()));
        if (t >= 2000) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    always @(posedge clk_sys_i) begin
        if (done) exp_q.push_back(note);
        if (rd_pend) begin
            rd_it = rd_q.pop_front();
            chk("read data", rd_it[31:0], reg_rdata_o & rd_it[63:32]);
        end
        rd_pend <= reg_rd_i;
    end
    always @(posedge recovered_clock_o) begin
        if (exp_q.size() != 0) begin
            exp_w = exp_q.pop_front();
            chk("rx word", {14'h0, exp_w}, {14'h0, rx_data_o,
                rx_k_flag_low_byte_o, rx_k_flag_high_byte_o});
        end
    end
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        err_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h8232d523));
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(SRX_REG_MODE, 32'h84, 32'hff);
        rd(SRX_REG_MASK, 32'h0, 32'hffffffff);
        rd(4'h2, 32'h0, 32'hffffffff);
        device_enable_i <= 1'b1;
        rd(SRX_REG_MODE, 32'h85, 32'hff);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys_i);
            preemphasis_high_i <= p[0];
            @(posedge clk_sys_i);
            chk("preemphasis", p ? 32'h14 : 32'h05,
                {27'h0, preemphasis_pct_o});
        end
        $display("power-up test done");
        repeat (3) i_srx_far_end.q.push_back({19'h0, 1'b1, CODE[4], CODE[4]});
        run <= 1'b1;
        for (int n = 0; n < 12; n++) begin
            grp($urandom_range(4), $urandom_range(4), 1'b1);
        end
        grp(0, 1, 1'b0);
        grp(2, 3, 1'b1);
        settle();
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wr(SRX_REG_MASK, 32'h1);
        @(posedge clk_sys_i);
        chk("irq", 32'h1, {31'h0, irq_o});
        rd(SRX_REG_STATUS, 32'h1, 32'h1);
        @(posedge clk_sys_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        wr(SRX_REG_COUNT, 32'h0);
        i_srx_far_end.q.push_back({19'h0, 1'b1, 10'h000, CODE[0]});
        settle();
        rd(SRX_REG_COUNT, 32'h1, 32'hffffffff);
        rd(SRX_REG_STATUS, 32'h4, 32'h4);
        $display("stream and status test done");
        loopback_enable_i <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            grp($urandom_range(4), $urandom_range(4), 1'b1);
        end
        @(posedge clk_sys_i);
        chk("tx oe in loop", 32'h0, {31'h0, serial_out_oe_o});
        settle();
        loopback_enable_i <= 1'b0;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        chk("tx oe", {30'h0, 1'b1, tx_serial_bit_i},
            {30'h0, serial_out_oe_o, serial_out_o});
        prbs_test_enable_i <= 1'b1;
        repeat (200) @(posedge clk_sys_i);
        chk("prbs pass", 32'h1, {31'h0, rx_k_flag_low_byte_o});
        prbs_test_enable_i <= 1'b0;
        $display("loopback and prbs test done");
        lock_to_reference_n_i <= 1'b0;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        chk("rx oe", 32'h1, {28'h0, rx_data_oe_o, rx_flags_oe_o,
            recovered_clock_oe_o, rx_ref_locked_o});
        rd(SRX_REG_MODE, 32'h2, 32'h7);
        lock_to_reference_n_i <= 1'b1;
        device_enable_i <= 1'b0;
        rd(SRX_REG_MODE, 32'h80, 32'h83);
        chk("powered", 32'h0, {31'h0, rx_powered_o});
        $display("reference and power-down test done");
        tally_and_finish();
    end
endmodule
bind srx_ctrl srx_props #(.POR_CYCLES(POR_CYCLES)) i_srx_props (.*);
`default_nettype wire
